/* File: core/lcs_consts.svh */
/*
 * Constants of the loop channel supervisor: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 200 MHz system clock and an 8-bit word address on the register port.
 */
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LCS_CLK_NS        5
`define LCS_MS_NS         1000000
`define LCS_MS_CYCLES     (`LCS_MS_NS / `LCS_CLK_NS)
`define LCS_MS_PER_S      10'h3E8
`define LCS_RECOVER_S     4
`define LCS_RECOVER_MS    16'(`LCS_RECOVER_S * 1000)
`define LCS_RETRY_MIN     1
`define LCS_RETRY_MS      16'(`LCS_RETRY_MIN * 60000)

// ----------------------------------------------------------------------------
// Address map: addr[7:6] selects the group, addr[5:4] the channel
// ----------------------------------------------------------------------------
`define LCS_GRP_CHAN      2'h0
`define LCS_GRP_DEV       2'h1
`define LCS_R_CFG         4'h0
`define LCS_R_HOLD        4'h1
`define LCS_R_ALMAX       4'h2
`define LCS_R_NOISE       4'h3
`define LCS_R_ADDR        4'h4
`define LCS_R_FRANGE      4'h5
`define LCS_R_STATUS      4'h6
`define LCS_R_COUNT       4'h7
`define LCS_R_INDUCT      4'h8
`define LCS_R_FREQ        4'h9
`define LCS_R_XFLAGS      4'hA
`define LCS_R_BUSADDR     4'hB
`define LCS_R_DEVFLAGS    4'h0
`define LCS_R_BAUD        4'h1
`define LCS_R_LEDOFF      4'h2
`define LCS_R_CMD         4'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LCS_CFG_NC        0
`define LCS_CFG_FLTFREE   1
`define LCS_CFG_AUTOREC   2
`define LCS_DF_MASTER     0
`define LCS_DF_BPOFF      1
`define LCS_CMD_CNTCLR    0
`define LCS_CMD_WAKE      1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LCS_BAUD_RST      32'h00002580
`define LCS_FRANGE_RST    32'hFFFF0000
`define LCS_XFLAGS_VAL    32'h00000001

`endif

/* File: core/lcs_pkg.sv */
/*
 * Types of the loop channel supervisor.
 * Assumes the constants header is included by the timebase and supervisor files.
 */
package lcs_pkg;
   typedef logic [15:0] lcs_half_t;
   typedef enum logic [1:0] {
      LCS_IDLE,
      LCS_OCC,
      LCS_IGNORE,
      LCS_RECOVER
   } lcs_state_t;
endpackage

/* File: core/lcs_tick_if.sv */
/*
 * Interface carrying the common millisecond and second ticks.
 * Assumes one source (the timebase) and any number of users.
 */
`timescale 1ns/100ps
interface lcs_tick_if;
   logic tick_ms;
   logic tick_s;
   modport src (output tick_ms, output tick_s);
   modport dst (input  tick_ms, input  tick_s);
endinterface // lcs_tick_if

/* File: core/lcs_timebase.sv */
/*
 * Free-running timebase giving millisecond and second ticks.
 * Assumes the system clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`include "lcs_consts.svh"
module lcs_timebase import lcs_pkg::*; #(
   parameter int TICK_CYCLES = `LCS_MS_CYCLES
) (
   input  wire logic   mclk_i,  // System clock.
   input  wire logic   rst_i,   // Asynchronous reset.
   lcs_tick_if.src     tick     // Tick outputs.
);
   logic [31:0] cyc_r;
   logic [9:0]  ms_r;
   wire         ms_wrap = (cyc_r == 32'(TICK_CYCLES - 1));
   wire         s_wrap  = ms_wrap && (ms_r == `LCS_MS_PER_S - 10'h001);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_r        <= 32'h0;
         ms_r         <= 10'h0;
         tick.tick_ms <= 1'b0;
         tick.tick_s  <= 1'b0;
      end else begin
         cyc_r        <= ms_wrap ? 32'h0 : cyc_r + 32'h1;
         ms_r         <= s_wrap ? 10'h0 : (ms_wrap ? ms_r + 10'h001 : ms_r);
         tick.tick_ms <= ms_wrap;
         tick.tick_s  <= s_wrap;
      end
   end
endmodule // lcs_timebase

/* File: core/lcs_clamp.sv */
/*
 * Registered clamp of a value between a lower and an upper bound.
 * Assumes lo <= hi; if not, the upper bound wins.
 */
`timescale 1ns/100ps
module lcs_clamp import lcs_pkg::*; (
   input  wire logic      mclk_i,  // System clock.
   input  wire logic      rst_i,   // Asynchronous reset.
   input  wire lcs_half_t val_i,   // Value to clamp.
   input  wire lcs_half_t lo_i,    // Lower bound.
   input  wire lcs_half_t hi_i,    // Upper bound.
   output lcs_half_t      q_o      // Clamped value, registered.
);
   wire lcs_half_t raised = (val_i < lo_i) ? lo_i : val_i;
   wire lcs_half_t cut    = (raised > hi_i) ? hi_i : raised;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) q_o <= 16'h0000;
      else       q_o <= cut;
   end
endmodule // lcs_clamp

/* File: core/lcs_supervisor.sv */
/*
 * Four-channel loop supervisor: hold time, recovery, output polarity,
 * alignment limit and retry, noise clamp, device flags, LED timer, status and
 * counters, behind a plain register port.
 * Assumes a loop front end that reports detection, fault, alignment activity,
 * switch-on threshold, inductance and frequency, synchronous to mclk_i.
 */
// Notes on behaviour
// - Hold-time expiry while occupied realigns channel.
// - Vehicle present at hold reset is ignored.
// - Sensitivity returns 4 s after vehicle leaves.
// - Hold time zero means infinite, never fires.
// - Polarity flag picks normally open or closed.
// - Detection inverts relay and open collector.
// - Fault drives output occupied unless flagged.
// - Nonzero alignment limit aborts and faults.
// - Auto recalibration retries faulted channel every minute.
// - Noise threshold clamped around switch-on threshold.
// - Baud rate register, default 9600.
// - Backplane disabled uses stored bus address.
// - Changing backplane flag resets the device.
// - LED timer turns LEDs off, wake restores.
// - Occupied, error, sticky history status bits.
// - Count alignments and hold exceedances.
// - Counter reset command clears both counters.
// - Inductance reported in 10 uH steps.
// - Frequency reported within configured range.
// - No writable sensitivity setting exists.
// - Extended channel flags are read-only.
`timescale 1ns/100ps
`include "lcs_consts.svh"
module lcs_supervisor import lcs_pkg::*; #(
   parameter int TICK_CYCLES = `LCS_MS_CYCLES
) (
   input  wire logic              mclk_i,         // System clock, 200 MHz.
   input  wire logic              rst_i,          // Asynchronous reset, active high.
   input  wire logic [7:0]        addr_i,         // Register word address.
   input  wire logic [31:0]       wdata_i,        // Write data.
   input  wire logic              wr_i,           // Write strobe.
   input  wire logic              rd_i,           // Read strobe.
   output logic [31:0]            rdata_o,        // Read data, cycle after rd_i.
   input  wire logic [3:0]        fe_detect_i,    // Detuning above switch-on level.
   input  wire logic [3:0]        fe_fault_i,     // Front end measurement fault.
   input  wire logic [3:0]        fe_align_i,     // Alignment in progress.
   input  wire logic [3:0][15:0]  fe_thr_i,       // Switch-on threshold.
   input  wire logic [3:0][15:0]  fe_induct_i,    // Inductance in uH.
   input  wire logic [3:0][15:0]  fe_freq_i,      // Frequency in kHz.
   input  wire logic [7:0]        bp_addr_i,      // Backplane address.
   input  wire logic              button_i,       // Short pushbutton press.
   input  wire logic              svc_act_i,      // Service interface activity.
   output logic [3:0]             align_req_o,    // Realign request pulse.
   output logic [3:0]             align_abort_o,  // Abort alignment pulse.
   output logic [3:0]             relay_o,        // Relay closed when high.
   output logic [3:0]             oc_o,           // Open collector level.
   output logic [3:0][15:0]       noise_o,        // Clamped noise threshold.
   output logic                   sync_master_o,  // Synchronisation master role.
   output logic [31:0]            baud_o,         // Data bus baud rate.
   output logic                   led_on_o,       // LEDs enabled.
   output logic                   dev_reset_o     // Full device reset pulse.
);
   // -------------------------------------------------------------------------
   // Timebase and register decode
   // -------------------------------------------------------------------------
   lcs_tick_if tick ();
   lcs_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .tick   (tick.src)
   );

   function automatic lcs_half_t quant10(input lcs_half_t v);
      logic [16:0] r;
      r = (17'(v) + 17'h00005) / 17'h0000A;
      // The top code 16'hFFFF would round past the 16-bit range, so it saturates instead.
      return (r > 17'h01999) ? 16'hFFFA : 16'(r * 17'h0000A);
   endfunction

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   wire        grp_chan = (addr_i[7:6] == `LCS_GRP_CHAN);
   wire        grp_dev  = (addr_i[7:6] == `LCS_GRP_DEV);
   wire [1:0]  sel_ch   = addr_i[5:4];
   wire [3:0]  sel_reg  = addr_i[3:0];
   wire        wr_dev   = wr_i && grp_dev;
   wire        wr_cmd   = wr_dev && (sel_reg == `LCS_R_CMD);
   wire        cnt_clr  = wr_cmd && wdata_i[`LCS_CMD_CNTCLR];
   wire        wake     = button_i || svc_act_i || (wr_cmd && wdata_i[`LCS_CMD_WAKE]);

   // -------------------------------------------------------------------------
   // Per-channel state
   // -------------------------------------------------------------------------
   logic [2:0]       cfg_r     [4];
   lcs_half_t        hold_r    [4];
   lcs_half_t        almax_r   [4];
   lcs_half_t        noise_r   [4];
   logic [7:0]       addr_r    [4];
   logic [31:0]      frange_r  [4];
   lcs_state_t       st_r      [4];
   lcs_half_t        hcnt_r    [4];
   lcs_half_t        rcnt_r    [4];
   lcs_half_t        acnt_r    [4];
   lcs_half_t        retry_r   [4];
   logic             flt_r     [4];
   logic             hist_r    [4];
   logic             align_d_r [4];
   lcs_half_t        nalign_r  [4];
   lcs_half_t        nhold_r   [4];
   lcs_half_t        freq_q    [4];
   logic [3:0]       err;
   logic [3:0]       occ;
   logic [3:0]       hold_fire;
   logic [31:0]      ch_rd     [4];

   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_ch
         wire        wr_me    = wr_i && grp_chan && (sel_ch == 2'(c));
         wire        align_up = fe_align_i[c] && !align_d_r[c];
         wire        ign      = (st_r[c] == LCS_IGNORE) || (st_r[c] == LCS_RECOVER);
         wire        hold_on  = (hold_r[c] != 16'h0000);
         wire        al_over  = fe_align_i[c] && (almax_r[c] != 16'h0000) && (acnt_r[c] >= almax_r[c]);
         wire        retry_go = flt_r[c] && cfg_r[c][`LCS_CFG_AUTOREC] && tick.tick_ms
                                && (retry_r[c] >= `LCS_RETRY_MS - 16'h0001);
         wire        active   = err[c] ? !cfg_r[c][`LCS_CFG_FLTFREE] : occ[c];
         wire [7:0]  bus_addr = cfg_dev_bpoff() ? addr_r[c] : 8'(bp_addr_i + 8'(c));
         lcs_state_t st_nxt;

         assign hold_fire[c] = hold_on && (st_r[c] == LCS_OCC) && fe_detect_i[c]
                               && (hcnt_r[c] >= hold_r[c]);
         assign err[c] = fe_fault_i[c] || flt_r[c];
         assign occ[c] = (st_r[c] == LCS_OCC) && !err[c];

         always_comb begin
            st_nxt = st_r[c];
            unique case (st_r[c])
               LCS_IDLE:    if (fe_detect_i[c]) st_nxt = LCS_OCC;
               LCS_OCC:     if (hold_fire[c]) st_nxt = LCS_IGNORE;
                            else if (!fe_detect_i[c]) st_nxt = LCS_IDLE;
               LCS_IGNORE:  if (!fe_detect_i[c]) st_nxt = LCS_RECOVER;
               LCS_RECOVER: if (fe_detect_i[c]) st_nxt = LCS_IGNORE;
                            else if (rcnt_r[c] >= `LCS_RECOVER_MS) st_nxt = LCS_IDLE;
            endcase
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               st_r[c]   <= LCS_IDLE;
               hcnt_r[c] <= 16'h0000;
               rcnt_r[c] <= 16'h0000;
            end else begin
               st_r[c]   <= st_nxt;
               hcnt_r[c] <= (st_r[c] != LCS_OCC) ? 16'h0000
                            : (tick.tick_s ? sat_inc(hcnt_r[c]) : hcnt_r[c]);
               rcnt_r[c] <= (st_r[c] != LCS_RECOVER || fe_detect_i[c]) ? 16'h0000
                            : (tick.tick_ms ? sat_inc(rcnt_r[c]) : rcnt_r[c]);
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               acnt_r[c]    <= 16'h0000;
               retry_r[c]   <= 16'h0000;
               flt_r[c]     <= 1'b0;
               align_d_r[c] <= 1'b0;
            end else begin
               align_d_r[c] <= fe_align_i[c];
               acnt_r[c]    <= !fe_align_i[c] ? 16'h0000
                               : (tick.tick_ms ? sat_inc(acnt_r[c]) : acnt_r[c]);
               retry_r[c]   <= (!flt_r[c] || retry_go) ? 16'h0000
                               : (tick.tick_ms ? sat_inc(retry_r[c]) : retry_r[c]);
               if (al_over) flt_r[c] <= 1'b1;
               else if (align_up) flt_r[c] <= 1'b0;
            end
         end

         // Counters: an increment in the cycle of a clear still counts once.
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               nalign_r[c] <= 16'h0000;
               nhold_r[c]  <= 16'h0000;
               hist_r[c]   <= 1'b0;
            end else begin
               if (align_up) nalign_r[c] <= cnt_clr ? 16'h0001 : sat_inc(nalign_r[c]);
               else if (cnt_clr) nalign_r[c] <= 16'h0000;
               if (hold_fire[c]) nhold_r[c] <= cnt_clr ? 16'h0001 : sat_inc(nhold_r[c]);
               else if (cnt_clr) nhold_r[c] <= 16'h0000;
               if (err[c]) hist_r[c] <= 1'b1;
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               cfg_r[c]    <= 3'h0;
               hold_r[c]   <= 16'h0000;
               almax_r[c]  <= 16'h0000;
               noise_r[c]  <= 16'h0000;
               addr_r[c]   <= 8'h00;
               frange_r[c] <= `LCS_FRANGE_RST;
            end else if (wr_me) begin
               if (sel_reg == `LCS_R_CFG)    cfg_r[c]    <= wdata_i[2:0];
               if (sel_reg == `LCS_R_HOLD)   hold_r[c]   <= wdata_i[15:0];
               if (sel_reg == `LCS_R_ALMAX)  almax_r[c]  <= wdata_i[15:0];
               if (sel_reg == `LCS_R_NOISE)  noise_r[c]  <= wdata_i[15:0];
               if (sel_reg == `LCS_R_ADDR)   addr_r[c]   <= wdata_i[7:0];
               if (sel_reg == `LCS_R_FRANGE) frange_r[c] <= wdata_i;
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               align_req_o[c]   <= 1'b0;
               align_abort_o[c] <= 1'b0;
               relay_o[c]       <= 1'b0;
               oc_o[c]          <= 1'b1;
            end else begin
               align_req_o[c]   <= hold_fire[c] || retry_go;
               align_abort_o[c] <= al_over;
               relay_o[c]       <= active ^ cfg_r[c][`LCS_CFG_NC];
               oc_o[c]          <= !(active ^ cfg_r[c][`LCS_CFG_NC]);
            end
         end

         lcs_clamp u_noise (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .val_i  (noise_r[c]),
            .lo_i   (fe_thr_i[c] >> 2),
            .hi_i   ((fe_thr_i[c][15]) ? 16'hFFFF : 16'(fe_thr_i[c] << 1)),
            .q_o    (noise_o[c])
         );

         lcs_clamp u_freq (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .val_i  (fe_freq_i[c]),
            .lo_i   (frange_r[c][15:0]),
            .hi_i   (frange_r[c][31:16]),
            .q_o    (freq_q[c])
         );

         // Sensitivity is not among the registers; writes to the extended flags are dropped.
         assign ch_rd[c] =
            (sel_reg == `LCS_R_CFG)     ? {29'h0, cfg_r[c]} :
            (sel_reg == `LCS_R_HOLD)    ? {16'h0, hold_r[c]} :
            (sel_reg == `LCS_R_ALMAX)   ? {16'h0, almax_r[c]} :
            (sel_reg == `LCS_R_NOISE)   ? {16'h0, noise_o[c]} :
            (sel_reg == `LCS_R_ADDR)    ? {24'h0, addr_r[c]} :
            (sel_reg == `LCS_R_FRANGE)  ? frange_r[c] :
            (sel_reg == `LCS_R_STATUS)  ? {28'h0, ign, hist_r[c], err[c], occ[c]} :
            (sel_reg == `LCS_R_COUNT)   ? {nhold_r[c], nalign_r[c]} :
            (sel_reg == `LCS_R_INDUCT)  ? {16'h0, quant10(fe_induct_i[c])} :
            (sel_reg == `LCS_R_FREQ)    ? {16'h0, freq_q[c]} :
            (sel_reg == `LCS_R_XFLAGS)  ? `LCS_XFLAGS_VAL :
            (sel_reg == `LCS_R_BUSADDR) ? {24'h0, bus_addr} : 32'h0;

         a_hold_infinite: assert property (@(posedge mclk_i) disable iff (rst_i)
            !hold_on && !cnt_clr |=> nhold_r[c] == $past(nhold_r[c])) else $error("hold counted with infinite hold time");
         a_hold_realign: assert property (@(posedge mclk_i) disable iff (rst_i)
            hold_fire[c] |=> align_req_o[c] && st_r[c] == LCS_IGNORE) else $error("hold expiry missed realign");
         a_ignore_silent: assert property (@(posedge mclk_i) disable iff (rst_i)
            ign && !err[c] |=> relay_o[c] == $past(cfg_r[c][`LCS_CFG_NC])) else $error("ignored vehicle reported occupied");
         a_recover_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
            st_r[c] == LCS_RECOVER && fe_detect_i[c] |=> st_r[c] == LCS_IGNORE && rcnt_r[c] == 16'h0000)
            else $error("recovery not restarted by vehicle");
         a_fault_output: assert property (@(posedge mclk_i) disable iff (rst_i)
            err[c] && !cfg_r[c][`LCS_CFG_FLTFREE] && $stable(cfg_r[c]) |=> relay_o[c] == !$past(cfg_r[c][`LCS_CFG_NC]))
            else $error("faulty channel not shown occupied");
         a_align_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
            al_over |=> flt_r[c] && $past(almax_r[c]) != 16'h0000) else $error("alignment limit not enforced");
         a_hist_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
            hist_r[c] |=> hist_r[c]) else $error("error history lost without power-on reset");
         a_count_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
            cnt_clr && !align_up && !hold_fire[c] |=> nalign_r[c] == 16'h0000 && nhold_r[c] == 16'h0000)
            else $error("counters not cleared");
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Device flags, baud rate, LED timer and read port
   // -------------------------------------------------------------------------
   logic [1:0]  devf_r;
   lcs_half_t   ledoff_r;
   lcs_half_t   ledcnt_r;
   wire         wr_devf  = wr_dev && (sel_reg == `LCS_R_DEVFLAGS);
   wire         led_exp  = (ledoff_r != 16'h0000) && (ledcnt_r >= ledoff_r);
   wire [31:0]  dev_rd   =
      (sel_reg == `LCS_R_DEVFLAGS) ? {30'h0, devf_r} :
      (sel_reg == `LCS_R_BAUD)     ? baud_o :
      (sel_reg == `LCS_R_LEDOFF)   ? {16'h0, ledoff_r} : 32'h0;
   wire [31:0]  rdata_nxt = !rd_i ? 32'h0 : grp_chan ? ch_rd[sel_ch] : grp_dev ? dev_rd : 32'h0;

   function automatic logic cfg_dev_bpoff();
      return devf_r[`LCS_DF_BPOFF];
   endfunction

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         devf_r        <= 2'h0;
         sync_master_o <= 1'b0;
         baud_o        <= `LCS_BAUD_RST;
         ledoff_r      <= 16'h0000;
         dev_reset_o   <= 1'b0;
      end else begin
         if (wr_devf) devf_r <= wdata_i[1:0];
         sync_master_o <= devf_r[`LCS_DF_MASTER];
         if (wr_dev && sel_reg == `LCS_R_BAUD) baud_o <= wdata_i;
         if (wr_dev && sel_reg == `LCS_R_LEDOFF) ledoff_r <= wdata_i[15:0];
         dev_reset_o <= wr_devf && (wdata_i[`LCS_DF_BPOFF] != devf_r[`LCS_DF_BPOFF]);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ledcnt_r <= 16'h0000;
         led_on_o <= 1'b1;
         rdata_o  <= 32'h0;
      end else begin
         ledcnt_r <= wake ? 16'h0000 : (tick.tick_s ? sat_inc(ledcnt_r) : ledcnt_r);
         led_on_o <= wake || !led_exp;
         rdata_o  <= rdata_nxt;
      end
   end

   a_bp_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_devf && wdata_i[`LCS_DF_BPOFF] != devf_r[`LCS_DF_BPOFF] |=> dev_reset_o)
      else $error("backplane flag change without device reset");
   a_led_wake: assert property (@(posedge mclk_i) disable iff (rst_i)
      wake |=> led_on_o ##1 led_on_o) else $error("LEDs not restored after wake");
   a_led_never_off: assert property (@(posedge mclk_i) disable iff (rst_i)
      ledoff_r == 16'h0000 && $past(ledoff_r) == 16'h0000 |-> led_on_o) else $error("LEDs off with timer disabled");
endmodule // lcs_supervisor

/* File: tb/lcs_fe_model.sv */
/*
 * Loop front end model: answers each realign request with one alignment.
 * Assumes the supervisor's request pulse is one cycle long.
 */
`timescale 1ns/100ps
module lcs_fe_model (
   input  wire logic       mclk_i,       // System clock.
   input  wire logic       rst_i,        // Asynchronous reset.
   input  wire logic [3:0] align_req_i,  // Realign request pulses.
   output logic [3:0]      fe_align_o    // Alignment in progress.
);
   logic [3:0][3:0] busy_r;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      for (int c = 0; c < 4; c++) begin
         if (rst_i) begin
            busy_r[c] <= 4'h0;
         end else if (align_req_i[c]) begin
            busy_r[c] <= 4'hA;  // One alignment per request.
         end else if (busy_r[c] != 4'h0) begin
            busy_r[c] <= busy_r[c] - 4'h1;
         end
      end
   end
   always_comb for (int c = 0; c < 4; c++) fe_align_o[c] = (busy_r[c] != 4'h0);
endmodule // lcs_fe_model

/* File: tb/test_loop_channel_supervisor.sv */
/*
 * Bench of the loop channel supervisor: registers, outputs, hold time, counters.
 * Assumes TICK_CYCLES of 4, so one second is 4000 clock cycles.
 */
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_loop_channel_supervisor;
   import lcs_pkg::*;
   logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, button_i = 0, svc_act_i = 0, rd_q = 0;
   logic [7:0] addr_i = 8'h00, bp_addr_i = 8'h10;
   logic [31:0] wdata_i = 32'h0, rdata_o, baud_o, ev, exp_q[$];
   logic [3:0] fe_detect_i = 4'h0, fe_fault_i = 4'h0, fe_align_i, align_req_o, align_abort_o, relay_o, oc_o;
   logic [3:0][15:0] fe_thr_i = {4{16'h0100}}, fe_induct_i = {4{16'h0093}}, fe_freq_i = {4{16'h0020}}, noise_o;
   logic sync_master_o, led_on_o, dev_reset_o;
   lcs_half_t nv;
   int mismatches = 0, cmp_count = 0, cyc = 0, seed = 22, rst_seen = 0, abort_seen = 0;
   always #2.5 mclk_i = ~mclk_i;
   lcs_supervisor #(.TICK_CYCLES(4)) i_lcs_supervisor (.*);
   lcs_fe_model i_lcs_fe_model (.mclk_i(mclk_i), .rst_i(rst_i), .align_req_i(align_req_o), .fe_align_o(fe_align_i));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // The note is queued here; the watcher below compares it when the data stand.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk_i);
      rd_i <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   always @(posedge mclk_i) begin
      rd_q <= rd_i;
      cyc++;
      if (dev_reset_o === 1'b1) rst_seen++;
      if (align_abort_o[2] === 1'b1) abort_seen++;
      if (rd_q) begin
         ev = exp_q.pop_front();
         `CHK("rdata", ev, rdata_o)
      end
      if (cyc > 90000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      wt(8);
      rst_i <= 1'b0;
      rd(8'h41, 32'h00002580);
      rd(8'hC0, 32'h0);
      wr(8'h0A, 32'h0);
      rd(8'h0A, 32'h00000001);
      rd(8'h05, 32'hFFFF0000);
      `CHK("idle", 2'b01, {relay_o[0], oc_o[0]})
      rd(8'h08, 32'h00000096);
      wr(8'h05, 32'h00300028);
      wt(2);
      rd(8'h09, 32'h00000028);
      rd(8'h1B, 32'h00000011);
      wr(8'h41, 32'h00004B00);
      wt(1);
      `CHK("baud", 32'h00004B00, baud_o)
      $display("registers done");
      // Noise is registered twice, so the read waits for the clamp to settle.
      for (int i = 0; i < 6; i++) begin
         nv = lcs_half_t'($random(seed)) >> (i * 2);
         wr(8'h03, {16'h0, nv});
         wt(2);
         rd(8'h03, (nv < 16'h0040) ? 32'h40 : (nv > 16'h0200) ? 32'h200 : {16'h0, nv});
      end
      $display("noise done");
      // Channel 2 shares the hold expiry and then overruns a 1 ms alignment limit.
      wr(8'h22, 32'h1);
      wr(8'h21, 32'h1);
      wr(8'h01, 32'h1);
      fe_detect_i <= 4'h5;
      wt(3);
      `CHK("occupied", 2'b10, {relay_o[0], oc_o[0]})
      wait (align_req_o[0] === 1'b1 || cyc > 20000);
      wt(20);
      `CHK("ignored", 1'b0, relay_o[0])
      `CHK("abort", 1'b1, abort_seen > 0)
      `CHK("limit fault", 1'b1, relay_o[2])
      rd(8'h26, 32'hE);
      rd(8'h07, 32'h00010001);
      fe_detect_i[0] <= 1'b0;
      wt(15000);
      fe_detect_i[0] <= 1'b1;
      wt(3);
      `CHK("recovering", 1'b0, relay_o[0])
      fe_detect_i[0] <= 1'b0;
      wt(17000);
      fe_detect_i[0] <= 1'b1;
      wt(3);
      `CHK("recovered", 1'b1, relay_o[0])
      fe_detect_i[0] <= 1'b0;
      wr(8'h43, 32'h1);
      rd(8'h07, 32'h0);
      $display("hold time done");
      fe_fault_i[1] <= 1'b1;
      wt(3);
      `CHK("fault out", 1'b1, relay_o[1])
      rd(8'h16, 32'h6);
      fe_fault_i[1] <= 1'b0;
      wt(3);
      rd(8'h16, 32'h4);
      wr(8'h04, 32'h55);
      wr(8'h40, 32'h3);
      wt(3);
      `CHK("master", 1'b1, sync_master_o)
      `CHK("dev reset", 1, rst_seen)
      rd(8'h0B, 32'h55);
      wt(3);
      $display("flags done");
      wr(8'h42, 32'h1);
      button_i <= 1'b1;
      wt(1);
      button_i <= 1'b0;
      wt(2);
      `CHK("led woken", 1'b1, led_on_o)
      wt(4005);
      `CHK("led off", 1'b0, led_on_o)
      svc_act_i <= 1'b1;
      wt(1);
      svc_act_i <= 1'b0;
      wt(2);
      `CHK("led service", 1'b1, led_on_o)
      $display("led done");
      end_sim();
   end
endmodule // test_loop_channel_supervisor
